// *** hw/ics_dev_end.sv ***
// Purpose: switch end: serial target with one channel-select register
// Assumes: link_clk oversamples the serial lines many times per bit
// Notes:   resetn also stands in for the supply-good reset
`timescale 1ns/1ns
module ics_dev_end
  import ics_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       resetn,
  input  wire logic       addr_strap_lsb,
  input  wire logic       addr_strap_mid,
  input  wire logic       addr_strap_msb,
  output logic      [7:0] chan_en,
  ics_link_if.device      link
);

  ics_dev_state_t state_r;
  logic           scl_m_r;
  logic           scl_s_r;
  logic           scl_d_r;
  logic           sda_m_r;
  logic           sda_s_r;
  logic           sda_d_r;
  logic [2:0]     strap_m_r;
  logic [2:0]     strap_s_r;
  logic [2:0]     por_cnt_r;
  logic           rst_int;
  logic [2:0]     cnt_r;
  logic           got_r;
  logic [7:0]     rx_r;
  logic [7:0]     tx_r;
  logic           rw_r;
  logic           nack_r;
  logic [7:0]     chan_sel_r;
  logic           pend_r;
  logic [7:0]     chan_en_r;
  logic           start_det;
  logic           stop_det;
  logic           scl_rise;
  logic           scl_fall;
  logic [6:0]     my_addr;
  logic           byte_wr;

  ////////////////////////////////////////////////////////////////////////////
  // power-on hold: logic stays in reset a few cycles past release
  always_ff @(posedge link_clk) begin
    if (!resetn) begin
      por_cnt_r <= 3'h0;
    end else if (por_cnt_r != POR_HOLD_CYCLES) begin
      por_cnt_r <= por_cnt_r + 3'h1;
    end
  end

  assign rst_int = !resetn || (por_cnt_r != POR_HOLD_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // line and strap synchronisers; idle lines read high
  always_ff @(posedge link_clk) begin
    if (!resetn) begin
      scl_m_r   <= 1'h1;
      scl_s_r   <= 1'h1;
      scl_d_r   <= 1'h1;
      sda_m_r   <= 1'h1;
      sda_s_r   <= 1'h1;
      sda_d_r   <= 1'h1;
      strap_m_r <= 3'h0;
      strap_s_r <= 3'h0;
    end else begin
      scl_m_r   <= link.scl;
      scl_s_r   <= scl_m_r;
      scl_d_r   <= scl_s_r;
      sda_m_r   <= link.sda;
      sda_s_r   <= sda_m_r;
      sda_d_r   <= sda_s_r;
      strap_m_r <= {addr_strap_msb, addr_strap_mid, addr_strap_lsb};
      strap_s_r <= strap_m_r;
    end
  end

  assign start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_det  = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  assign scl_rise  = scl_s_r && !scl_d_r;
  assign scl_fall  = !scl_s_r && scl_d_r;
  assign my_addr   = TARGET_ADDR_BASE | {4'h0, strap_s_r};

  ////////////////////////////////////////////////////////////////////////////
  // serial state machine
  always_ff @(posedge link_clk) begin
    if (rst_int) begin
      state_r <= DS_IDLE;
      cnt_r   <= 3'h0;
      got_r   <= 1'h0;
      rx_r    <= 8'h00;
      tx_r    <= 8'h00;
      rw_r    <= 1'h0;
      nack_r  <= 1'h0;
    end else if (start_det) begin
      state_r <= DS_ADDR;
      cnt_r   <= 3'h0;
      got_r   <= 1'h0;
    end else if (stop_det) begin
      state_r <= DS_IDLE;
      got_r   <= 1'h0;
    end else begin
      if (scl_rise) begin
        case (state_r)
          DS_ADDR, DS_WDATA, DS_RDATA: begin
            rx_r  <= {rx_r[6:0], sda_s_r};
            cnt_r <= cnt_r + 3'h1;
            got_r <= (cnt_r == 3'h7);
          end
          DS_RACK: begin
            nack_r <= sda_s_r;
          end
          default: begin
          end
        endcase
      end
      if (scl_fall) begin
        case (state_r)
          DS_ADDR: begin
            if (got_r) begin
              got_r <= 1'h0;
              if (rx_r[7:1] == my_addr) begin
                rw_r    <= rx_r[0];
                state_r <= DS_AACK;
              end else begin
                state_r <= DS_IGNORE;
              end
            end
          end
          DS_AACK: begin
            if (rw_r == RW_READ) begin
              state_r <= DS_RDATA;
              tx_r    <= chan_sel_r;
            end else begin
              state_r <= DS_WDATA;
            end
          end
          DS_WDATA: begin
            if (got_r) begin
              got_r   <= 1'h0;
              state_r <= DS_WACK;
            end
          end
          DS_WACK: begin
            state_r <= DS_WDATA;
          end
          DS_RDATA: begin
            if (got_r) begin
              got_r   <= 1'h0;
              state_r <= DS_RACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'h0};
            end
          end
          DS_RACK: begin
            if (nack_r) begin
              state_r <= DS_IGNORE;
            end else begin
              state_r <= DS_RDATA;
              tx_r    <= chan_sel_r;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign byte_wr = scl_fall && got_r && (state_r == DS_WDATA) && !start_det && !stop_det;

  ////////////////////////////////////////////////////////////////////////////
  // channel-select register; every new byte overwrites the last
  always_ff @(posedge link_clk) begin
    if (rst_int) begin
      chan_sel_r <= CHAN_SEL_RESET;
      pend_r     <= 1'h0;
    end else if (start_det || stop_det) begin
      pend_r <= 1'h0;
    end else if (byte_wr) begin
      chan_sel_r <= rx_r;
      pend_r     <= 1'h1;
    end
  end

  // enables move only at stop so channels join with idle-high lines
  always_ff @(posedge link_clk) begin
    if (rst_int) begin
      chan_en_r <= CHAN_SEL_RESET;
    end else if (stop_det && pend_r) begin
      chan_en_r <= chan_sel_r;
    end
  end

  assign chan_en = chan_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // data line drive: ack slots and zero bits of read data
  assign link.sda_out_dev = 1'h0;
  assign link.sda_oe_dev  = (state_r == DS_AACK) || (state_r == DS_WACK)
                            || ((state_r == DS_RDATA) && !tx_r[7]);

endmodule : ics_dev_end

// *** hw/ics_host_end.sv ***
// Purpose: controller end: runs one serial transfer per command
// Assumes: software waits for busy to drop before a new command
// Notes:   serial clock is divided from clk; no clock stretching
`timescale 1ns/1ns
module ics_host_end
  import ics_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  ics_link_if.host        link
);

  ics_host_state_t hstate_r;
  logic [6:0]      tgt_r;
  logic [7:0]      txd_r;
  logic [3:0]      len_r;
  logic [7:0]      rxd_r;
  logic            busy_r;
  logic            anack_r;
  logic            dnack_r;
  logic [7:0]      rdata_r;
  logic [6:0]      qcnt_r;
  logic [1:0]      quarter_r;
  logic [3:0]      bit_r;
  logic [7:0]      shift_r;
  logic [3:0]      rem_r;
  logic            is_addr_r;
  logic            rw_r;
  logic            scl_r;
  logic            sda_r;
  logic            sda_m_r;
  logic            sda_s_r;
  logic            tick;
  logic            go;
  logic            drv_bit;
  logic            send_mode;

  assign tick      = (qcnt_r == SCL_QTR_LAST);
  assign go        = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_GO_POS] && !busy_r;
  assign send_mode = is_addr_r || (rw_r != RW_READ);
  // read: release data bits, ack all but the last byte
  assign drv_bit   = (bit_r == 4'h8) ? (send_mode || (rem_r == 4'h1))
                                     : (send_mode ? shift_r[7] : 1'h1);

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tgt_r <= TARGET_RESET;
      txd_r <= 8'h00;
      len_r <= LEN_RESET;
    end else if (reg_wr) begin
      if (reg_addr == REG_TARGET && !busy_r) begin
        tgt_r <= reg_wdata[6:0];
      end
      if (reg_addr == REG_TXDATA) begin
        txd_r <= reg_wdata;
      end
      if (reg_addr == REG_LEN && !busy_r) begin
        len_r <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_TARGET: rdata_r <= {1'h0, tgt_r};
        REG_TXDATA: rdata_r <= txd_r;
        REG_LEN:    rdata_r <= {4'h0, len_r};
        REG_STATUS: rdata_r <= {5'h00, dnack_r, anack_r, busy_r};
        REG_RXDATA: rdata_r <= rxd_r;
        default:    rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // data line synchroniser and quarter-bit divider
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sda_m_r <= 1'h1;
      sda_s_r <= 1'h1;
    end else begin
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || hstate_r == HS_IDLE || tick) begin
      qcnt_r <= 7'h00;
    end else begin
      qcnt_r <= qcnt_r + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine; data changes a quarter after the clock falls
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hstate_r  <= HS_IDLE;
      quarter_r <= 2'h0;
      bit_r     <= 4'h0;
      shift_r   <= 8'h00;
      rem_r     <= 4'h0;
      is_addr_r <= 1'h0;
      rw_r      <= 1'h0;
      scl_r     <= 1'h1;
      sda_r     <= 1'h1;
      busy_r    <= 1'h0;
      anack_r   <= 1'h0;
      dnack_r   <= 1'h0;
      rxd_r     <= 8'h00;
    end else begin
      case (hstate_r)
        HS_IDLE: begin
          if (go) begin
            hstate_r  <= HS_START;
            quarter_r <= 2'h0;
            bit_r     <= 4'h0;
            rw_r      <= reg_wdata[CMD_RW_POS];
            shift_r   <= {tgt_r, reg_wdata[CMD_RW_POS]};
            rem_r     <= (len_r == 4'h0 && reg_wdata[CMD_RW_POS]) ? 4'h1 : len_r;
            is_addr_r <= 1'h1;
            busy_r    <= 1'h1;
            anack_r   <= 1'h0;
            dnack_r   <= 1'h0;
          end
        end
        HS_START: begin
          if (tick) begin
            if (quarter_r == 2'h0) begin
              sda_r     <= 1'h0;
              quarter_r <= 2'h1;
            end else begin
              scl_r     <= 1'h0;
              quarter_r <= 2'h0;
              hstate_r  <= HS_BIT;
            end
          end
        end
        HS_BIT: begin
          if (tick) begin
            quarter_r <= quarter_r + 2'h1;
            case (quarter_r)
              2'h0: sda_r <= drv_bit;
              2'h1: scl_r <= 1'h1;
              2'h3: begin
                scl_r <= 1'h0;
                if (bit_r != 4'h8) begin
                  shift_r <= {shift_r[6:0], sda_s_r};
                  bit_r   <= bit_r + 4'h1;
                end else begin
                  bit_r   <= 4'h0;
                  shift_r <= txd_r;
                  if (is_addr_r) begin
                    is_addr_r <= 1'h0;
                    if (sda_s_r) begin
                      anack_r  <= 1'h1;
                      hstate_r <= HS_STOP;
                    end else if (rem_r == 4'h0) begin
                      hstate_r <= HS_STOP;
                    end
                  end else begin
                    rem_r <= rem_r - 4'h1;
                    if (rw_r == RW_READ) begin
                      rxd_r <= shift_r;
                    end else if (sda_s_r) begin
                      dnack_r <= 1'h1;
                    end
                    if (rem_r == 4'h1 || (rw_r != RW_READ && sda_s_r)) begin
                      hstate_r <= HS_STOP;
                    end
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
        HS_STOP: begin
          if (tick) begin
            quarter_r <= quarter_r + 2'h1;
            case (quarter_r)
              2'h0: sda_r <= 1'h0;
              2'h1: scl_r <= 1'h1;
              2'h2: sda_r <= 1'h1;
              default: begin
                hstate_r <= HS_IDLE;
                busy_r   <= 1'h0;
              end
            endcase
          end
        end
        default: begin
          hstate_r <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.scl_out      = 1'h0;
  assign link.scl_oe       = !scl_r;
  assign link.sda_out_host = 1'h0;
  assign link.sda_oe_host  = !sda_r;

endmodule : ics_host_end

// *** hw/ics_link_if.sv ***
// Purpose: upstream serial link between controller end and switch end
// Assumes: open-drain lines with pull-ups, high when nobody drives
// Notes:   only the controller drives the clock line
`timescale 1ns/1ns
interface ics_link_if;
  logic scl_out;
  logic scl_oe;
  logic sda_out_host;
  logic sda_oe_host;
  logic sda_out_dev;
  logic sda_oe_dev;
  logic scl;
  logic sda;

  // wired-and of the open-drain drivers
  assign scl = (scl_oe && !scl_out) ? 1'b0 : 1'b1;
  assign sda = ((sda_oe_host && !sda_out_host) || (sda_oe_dev && !sda_out_dev)) ? 1'b0 : 1'b1;

  modport host (
    output scl_out,
    output scl_oe,
    output sda_out_host,
    output sda_oe_host,
    input  scl,
    input  sda
  );

  modport device (
    output sda_out_dev,
    output sda_oe_dev,
    input  scl,
    input  sda
  );
endinterface : ics_link_if

// *** hw/ics_pkg.sv ***
// Purpose: shared constants and types for the i2c channel switch, both ends
// Assumes: host end on clk at 100 MHz, device end on the link clock
// Notes:   offsets are byte addresses of the host register port
//
// Functional notes
// - answer at 0x71..0x77 for nonzero straps
// - all straps low gives address 0x70
// - byte after address is register data
// - write is start, address with rw 0, data, stop
// - any byte count, last byte kept
// - rw 1 reads register contents back
// - controller releases data line while reading
// - controller acks wanted bytes, nacks last, stops
// - register bit n enables channel n
// - any channel combination may be enabled
// - new selection applied only at stop
// - controller stops right after last ack
// - register writable and readable over serial bus
// - register clears to zero at reset
// - reset pin clears register, fsm, channels
// - reset pin held low at least 6 ns
// - power-on hold keeps logic reset, then defaults
package ics_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int         CLK_FREQ_HZ            = 32'h05F5_E100;
  localparam int         SCL_FREQ_HZ            = 32'h0006_1A80;
  localparam int         SCL_QTR_CYCLES         = (CLK_FREQ_HZ + 4 * SCL_FREQ_HZ - 1)
                                                  / (4 * SCL_FREQ_HZ);
  localparam logic [6:0] SCL_QTR_LAST           = 7'(SCL_QTR_CYCLES - 1);
  localparam int         LINK_CLK_PERIOD_NS     = 32'h0000_0030;
  localparam int         RESET_MIN_LOW_WIDTH_NS = 32'h0000_0006;
  localparam int         RESET_MIN_RAW          = (RESET_MIN_LOW_WIDTH_NS + LINK_CLK_PERIOD_NS - 1)
                                                  / LINK_CLK_PERIOD_NS;
  localparam int         RESET_MIN_CYCLES       = (RESET_MIN_RAW < 1) ? 1 : RESET_MIN_RAW;
  localparam logic [2:0] POR_HOLD_CYCLES        = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // device address and register
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h70;
  localparam logic [7:0] CHAN_SEL_RESET   = 8'h00;
  localparam logic       RW_READ          = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // host register port
  localparam logic [7:0] REG_TARGET   = 8'h00;
  localparam logic [7:0] REG_TXDATA   = 8'h04;
  localparam logic [7:0] REG_LEN      = 8'h08;
  localparam logic [7:0] REG_CMD      = 8'h0C;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_RXDATA   = 8'h14;
  localparam int         CMD_GO_POS   = 0;
  localparam int         CMD_RW_POS   = 1;
  localparam int         ST_BUSY_POS  = 0;
  localparam int         ST_ANACK_POS = 1;
  localparam int         ST_DNACK_POS = 2;
  localparam logic [6:0] TARGET_RESET = 7'h70;
  localparam logic [3:0] LEN_RESET    = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // state machines
  typedef enum logic [2:0] {
    DS_IDLE   = 3'h0,
    DS_ADDR   = 3'h1,
    DS_AACK   = 3'h3,
    DS_WDATA  = 3'h2,
    DS_WACK   = 3'h6,
    DS_RDATA  = 3'h7,
    DS_RACK   = 3'h5,
    DS_IGNORE = 3'h4
  } ics_dev_state_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_START = 2'h1,
    HS_BIT   = 2'h3,
    HS_STOP  = 2'h2
  } ics_host_state_t;

endpackage : ics_pkg

// *** verif/ics_link_assertions.sv ***
// Purpose: concurrent checks on the serial link and the host register port
// Assumes: link lines sampled raw in each clock domain
// Notes:   stop age bounds how late the enables may follow a stop
`timescale 1ns/1ns
module ics_link_assertions
  import ics_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       link_clk,
  input wire logic       dev_resetn,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       scl_oe,
  input wire logic       sda_oe_host,
  input wire logic       sda_oe_dev,
  input wire logic [7:0] chan_en
);
  localparam int IDLE_HIGH = 200;
  // clock high spans two quarter-bit periods of the host divider
  localparam int HALF_BIT  = 2 * SCL_QTR_CYCLES;

  ////////////////////////////////////////////////////////////////////////////
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] stop_age_r;
  logic [7:0] high_cnt_r;

  always_ff @(posedge link_clk) begin
    scl_q_r <= scl;
    sda_q_r <= sda;
  end

  // saturating, so a long idle never wraps back into the bound
  always_ff @(posedge link_clk) begin
    if (!dev_resetn) stop_age_r <= 4'hF;
    else if (scl && scl_q_r && sda && !sda_q_r) stop_age_r <= 4'h0;
    else if (stop_age_r != 4'hF) stop_age_r <= stop_age_r + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (!resetn || !scl) high_cnt_r <= 8'h00;
    else if (high_cnt_r != 8'hFF) high_cnt_r <= high_cnt_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  reset_clear_a: assert property (@(posedge link_clk) disable iff (!dev_resetn)
    $rose(dev_resetn) |-> chan_en == 8'h00) else $error("enables not cleared by reset");
  por_hold_a: assert property (@(posedge link_clk) disable iff (!dev_resetn)
    $rose(dev_resetn) |-> (chan_en == 8'h00 && !sda_oe_dev) [*4])
    else $error("device active during reset hold");
  stop_apply_a: assert property (@(posedge link_clk) disable iff (!dev_resetn)
    $changed(chan_en) && $past(dev_resetn) |-> stop_age_r < 4'h8)
    else $error("enables changed without a stop");
  sda_hold_a: assert property (@(posedge link_clk) disable iff (!dev_resetn)
    scl && scl_q_r && $past(dev_resetn) |-> $stable(sda_oe_dev))
    else $error("device moved data while clock high");
  scl_high_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(scl) && high_cnt_r < IDLE_HIGH |-> high_cnt_r == HALF_BIT)
    else $error("clock high time wrong");
  host_release_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> !scl_oe && !sda_oe_host) else $error("host drives link after reset");
  rdata_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
  cmd_read_a: assert property (@(posedge clk) disable iff (!resetn)
    reg_rd && (reg_addr == REG_CMD || reg_addr > REG_RXDATA) |=> reg_rdata == 8'h00)
    else $error("write-only or unmapped read not zero");

  cover property (@(posedge link_clk) disable iff (!dev_resetn) $changed(chan_en));
  cover property (@(posedge link_clk) disable iff (!dev_resetn) $rose(sda_oe_dev));
  cover property (@(posedge clk) disable iff (!resetn) reg_rd && reg_addr == REG_RXDATA);
endmodule : ics_link_assertions

// *** verif/tb.sv ***
// Purpose: both ends joined on one link, driven through the host registers
// Assumes: straps change only while the link is idle
// Notes:   mid-transfer data update relies on per-byte sampling of txdata
`timescale 1ns/1ns
module tb;
  import ics_pkg::*;

  typedef struct packed {
    logic [2:0] strap;
    logic       rw;
    logic [7:0] data;
  } ics_row_t;

  logic       clk;
  logic       resetn;
  logic       link_clk;
  logic       dev_resetn;
  logic [2:0] straps;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] chan_en;
  logic [7:0] status;
  logic [7:0] val;
  logic [7:0] last;
  int         failures;
  int         compares;
  ics_row_t   rows [8] = '{'{3'h0, 1'b1, 8'h00}, '{3'h1, 1'b0, 8'h5A}, '{3'h2, 1'b1, 8'h5A},
                           '{3'h3, 1'b0, 8'h81}, '{3'h4, 1'b1, 8'h81}, '{3'h5, 1'b0, 8'hFF},
                           '{3'h6, 1'b1, 8'hFF}, '{3'h7, 1'b0, 8'h24}};

  ics_link_if link ();
  ics_host_end u_ics_host_end (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link(link.host));
  ics_dev_end u_ics_dev_end (.link_clk(link_clk), .resetn(dev_resetn),
    .addr_strap_lsb(straps[0]), .addr_strap_mid(straps[1]), .addr_strap_msb(straps[2]),
    .chan_en(chan_en), .link(link.device));
  ics_link_assertions u_ics_link_assertions (.clk(clk), .resetn(resetn), .link_clk(link_clk),
    .dev_resetn(dev_resetn), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .scl(link.scl), .sda(link.sda), .scl_oe(link.scl_oe), .sda_oe_host(link.sda_oe_host),
    .sda_oe_dev(link.sda_oe_dev), .chan_en(chan_en));

  ////////////////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // odd offset keeps the link clock out of phase with clk
  initial begin
    link_clk = 1'b0;
    #7;
    forever #(LINK_CLK_PERIOD_NS / 2) link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic start_x(input logic [6:0] tgt, input logic rw, input logic [3:0] len,
                         input logic [7:0] d);
    wr(REG_TARGET, {1'b0, tgt});
    wr(REG_TXDATA, d);
    wr(REG_LEN, {4'h0, len});
    wr(REG_CMD, {6'h00, rw, 1'b1});
  endtask : start_x

  // polling bound stands well above the longest transfer used here
  task automatic wait_x();
    int n;
    n = 0;
    do begin
      rd(REG_STATUS, status);
      n++;
    end while (status[ST_BUSY_POS] !== 1'b0 && n < 20000);
    if (n >= 20000) failures++;
  endtask : wait_x

  task automatic test_done();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // expected run is near 67k clk; the limit leaves margin yet stays under 100k
  initial begin
    #950_000;
    failures++;
    test_done();
  end

  initial begin
    resetn     = 1'b0;
    dev_resetn = 1'b0;
    straps     = 3'h0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    last       = 8'h00;
    failures   = 0;
    compares   = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge link_clk);
    dev_resetn <= 1'b1;
    repeat (10) @(posedge link_clk);
    chk(chan_en, 8'h00);
    foreach (rows[i]) begin
      @(posedge link_clk);
      straps <= rows[i].strap;
      repeat (8) @(posedge link_clk);
      start_x(TARGET_ADDR_BASE | {4'h0, rows[i].strap}, rows[i].rw, 4'h1, rows[i].data);
      wait_x();
      chk(status, 8'h00);
      if (rows[i].rw) begin
        rd(REG_RXDATA, val);
        chk(val, rows[i].data);
      end else begin
        last = rows[i].data;
      end
      chk(chan_en, last);
    end
    @(posedge link_clk);
    straps <= 3'h3;
    repeat (8) @(posedge link_clk);
    start_x(7'h75, 1'b0, 4'h1, 8'h3C);
    wait_x();
    chk(status, 8'h02);
    chk(chan_en, last);
    start_x(7'h73, 1'b0, 4'h3, 8'h11);
    repeat (3500) @(posedge clk);
    wr(REG_TXDATA, 8'h99);
    wait_x();
    chk(status, 8'h00);
    chk(chan_en, 8'h99);
    start_x(7'h73, 1'b1, 4'h2, 8'h00);
    wait_x();
    chk(status, 8'h00);
    rd(REG_RXDATA, val);
    chk(val, 8'h99);
    rd(REG_CMD, val);
    chk(val, 8'h00);
    start_x(7'h73, 1'b0, 4'h0, 8'h00);
    wait_x();
    chk(chan_en, 8'h99);
    @(posedge link_clk);
    dev_resetn <= 1'b0;
    repeat (RESET_MIN_CYCLES) @(posedge link_clk);
    dev_resetn <= 1'b1;
    repeat (2) @(posedge link_clk);
    chk(chan_en, 8'h00);
    repeat (10) @(posedge link_clk);
    start_x(7'h73, 1'b1, 4'h1, 8'h00);
    wait_x();
    rd(REG_RXDATA, val);
    chk(val, 8'h00);
    test_done();
  end
endmodule : tb
